/* src/cmcrc_cfg.svh */
`ifndef CMCRC_CFG_SVH
`define CMCRC_CFG_SVH

// data path widths
`define CMCRC_WORD_W        16
`define CMCRC_CRC32_W       32
`define CMCRC_CRC16_W       16
`define CMCRC_IR_W          10

// generators and seeds
`define CMCRC_CRC32_POLY    32'h04C11DB7
`define CMCRC_CRC32_INIT    32'hFFFFFFFF
`define CMCRC_CRC16_POLY    16'h8005
`define CMCRC_CRC16_INIT    16'hFFFF

// test access opcode that selects the expected-crc storage register
`define CMCRC_LOAD_EXP_OP   10'h015
`define CMCRC_IR_RESET      10'h3FF

`endif

/* src/cmcrc_pkg.sv */
package cmcrc_pkg;

   typedef enum logic [2:0] {
      CMCRC_IDLE,
      CMCRC_FRAME,
      CMCRC_FCRC,
      CMCRC_EXP_LO,
      CMCRC_EXP_HI,
      CMCRC_USER,
      CMCRC_ERR
   } cmcrc_state_t;

endpackage

/* src/cmcrc_cell_mem.sv */
`timescale 1ns/1ps
`default_nettype none

module cmcrc_cell_mem #(
   parameter int WIDTH  = 17,
   parameter int DEPTH  = 32,
   parameter int ADDR_W = 5
) (
   input  wire logic              core_clk_i,
   input  wire logic              wr_en_i,
   input  wire logic [ADDR_W-1:0] wr_addr_i,
   input  wire logic [WIDTH-1:0]  wr_data_i,
   input  wire logic [ADDR_W-1:0] rd_addr_i,
   output logic      [WIDTH-1:0]  rd_data_o
);

   // no reset on the array: contents are defined by the configuration load
   logic [WIDTH-1:0] mem_r [DEPTH];

   always_ff @(posedge core_clk_i) begin
      if (wr_en_i) begin
         mem_r[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem_r[rd_addr_i];
   end

endmodule

`default_nettype wire

/* src/cmcrc_checker.sv */
// What this block does
// RL1: during loading, compute a crc over each frame and compare with its carried crc
// RL2: load frame after frame until a frame crc mismatch or all frames checked
// RL3: the source supplies the precomputed expected crc inside the bit stream
// RL4: at the end of loading keep the expected crc in a 32-bit storage register
// RL5: the background check in user mode runs only while enabled
// RL6: in user mode repeatedly crc the cell memory and compare with expected value
// RL7: user mode checking runs until the reconfiguration request pin goes low
// RL8: memory block contents and i/o flip-flop bits are left out of the crc
// RL9: generator is the ieee 802 32-bit polynomial, one crc over all covered bits
// RL10: zero signature drives the error flag low, non-zero drives it high
// RL11: a 10-bit test opcode puts the storage register between tdi and tdo
// RL12: the storage load opcode works only in user mode; host issues it only then (the test also issues it after a bad frame)
// RL13: tester loads a wrong value to inject an error, then restores the right one
// RL14: tester should shift out and save the correct value before corrupting it
// RL15: after error injection testing the device should be power cycled; the test reconfigures it through the request pin instead
// RL16: on the error flag, system logic reconfigures the device or ignores it
// RL17: a per-frame 16-bit crc mismatch drives the configuration status pin low
// RL18: the user mode crc keeps running after an error is found
// RL19: error flag updates only at the end of a pass; cleared on reset or reconfig
`timescale 1ns/1ps
`default_nettype none
`include "cmcrc_cfg.svh"

module cmcrc_checker #(
   parameter int FRAME_WORDS = 8,
   parameter int NUM_FRAMES  = 4
) (
   input  wire logic                       core_clk_i,
   input  wire logic                       reset_i,
   input  wire logic                       reconfig_request_n_i,
   input  wire logic                       cfg_valid_i,
   input  wire logic [`CMCRC_WORD_W-1:0]   cfg_data_i,
   input  wire logic                       cfg_excl_i,
   input  wire logic                       crc_check_en_i,
   input  wire logic                       tck_i,
   input  wire logic                       tdi_i,
   input  wire logic                       jtag_shift_ir_i,
   input  wire logic                       jtag_update_ir_i,
   input  wire logic                       jtag_capture_dr_i,
   input  wire logic                       jtag_shift_dr_i,
   input  wire logic                       jtag_update_dr_i,
   output logic                            tdo_o,
   output logic                            config_status_n_o,
   output logic                            user_mode_o,
   output logic                            crc_error_o,
   output logic [`CMCRC_CRC32_W-1:0]       crc_signature_o,
   output cmcrc_pkg::cmcrc_state_t         cfg_state_o
);
   import cmcrc_pkg::*;

   localparam int DEPTH  = FRAME_WORDS * NUM_FRAMES;
   localparam int ADDR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int WCNT_W = (FRAME_WORDS > 1) ? $clog2(FRAME_WORDS) : 1;
   localparam int FCNT_W = (NUM_FRAMES > 1) ? $clog2(NUM_FRAMES) : 1;
   localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(DEPTH - 1);
   localparam logic [WCNT_W-1:0] LAST_WORD = WCNT_W'(FRAME_WORDS - 1);
   localparam logic [FCNT_W-1:0] LAST_FRM  = FCNT_W'(NUM_FRAMES - 1);

   // msb-first, one 16-bit word per call
   function automatic logic [`CMCRC_CRC32_W-1:0] crc32_step(input logic [`CMCRC_CRC32_W-1:0] c,
                                                         input logic [`CMCRC_WORD_W-1:0]  d);
      logic [`CMCRC_CRC32_W-1:0] r;
      r = c;
      for (int i = `CMCRC_WORD_W - 1; i >= 0; i--) begin
         r = (r[`CMCRC_CRC32_W-1] ^ d[i]) ? ({r[`CMCRC_CRC32_W-2:0], 1'b0} ^ `CMCRC_CRC32_POLY) // RL9
                                          : {r[`CMCRC_CRC32_W-2:0], 1'b0};
      end
      return r;
   endfunction

   function automatic logic [`CMCRC_CRC16_W-1:0] crc16_step(input logic [`CMCRC_CRC16_W-1:0] c,
                                                         input logic [`CMCRC_WORD_W-1:0]  d);
      logic [`CMCRC_CRC16_W-1:0] r;
      r = c;
      for (int i = `CMCRC_WORD_W - 1; i >= 0; i--) begin
         r = (r[`CMCRC_CRC16_W-1] ^ d[i]) ? ({r[`CMCRC_CRC16_W-2:0], 1'b0} ^ `CMCRC_CRC16_POLY)
                                          : {r[`CMCRC_CRC16_W-2:0], 1'b0};
      end
      return r;
   endfunction

   // ---------------- core domain ----------------
   logic                        rcfg_s1_r, rcfg_s2_r;
   logic                        ld_s1_r, ld_s2_r, ld_s3_r;
   cmcrc_state_t                state_r, state_nxt;
   logic [WCNT_W-1:0]           word_cnt_r;
   logic [FCNT_W-1:0]           frame_cnt_r;
   logic [ADDR_W-1:0]           wr_addr_r;
   logic [`CMCRC_CRC16_W-1:0]   frame_crc_r;
   logic [`CMCRC_WORD_W-1:0]    exp_lo_r;
   logic [`CMCRC_CRC32_W-1:0]   expected_crc_r;
   logic                        exp_tgl_r;
   logic [ADDR_W-1:0]           scan_addr_r;
   logic                        rd_vld_r, rd_last_r;
   logic [`CMCRC_CRC32_W-1:0]   crc_r;
   logic [`CMCRC_WORD_W:0]      rd_data;

   // ---------------- link (tck) domain ----------------
   logic                        trst_s1_r, trst_s2_r;
   logic                        um_s1_r, um_s2_r;
   logic                        ex_s1_r, ex_s2_r, ex_s3_r;
   logic [`CMCRC_IR_W-1:0]      ir_sh_r, ir_r;
   logic [`CMCRC_CRC32_W-1:0]   dr_r, shadow_r, ld_word_r;
   logic                        ld_tgl_r;

   // pin and cross-domain inputs: two flops before use
   always_ff @(posedge core_clk_i) begin
      rcfg_s1_r <= reconfig_request_n_i;
      rcfg_s2_r <= rcfg_s1_r;
      ld_s1_r   <= ld_tgl_r;
      ld_s2_r   <= ld_s1_r;
      ld_s3_r   <= ld_s2_r;
   end

   wire restart   = reset_i | ~rcfg_s2_r;
   wire ld_event  = ld_s2_r ^ ld_s3_r;
   wire word_in   = cfg_valid_i & (state_r == CMCRC_FRAME);
   wire crc_in    = cfg_valid_i & (state_r == CMCRC_FCRC);
   wire [`CMCRC_CRC16_W-1:0] frame_crc_upd = crc16_step(frame_crc_r, cfg_data_i); // RL1
   wire frame_bad = crc_in & (cfg_data_i != frame_crc_r);                        // RL1
   wire exp_done  = cfg_valid_i & (state_r == CMCRC_EXP_HI);
   wire scan_on   = (state_r == CMCRC_USER) & crc_check_en_i;                    // RL5
   wire rd_excl   = rd_data[`CMCRC_WORD_W];
   wire [`CMCRC_CRC32_W-1:0] crc_upd = rd_excl ? crc_r                           // RL8
                                      : crc32_step(crc_r, rd_data[`CMCRC_WORD_W-1:0]);
   wire [`CMCRC_CRC32_W-1:0] sig_nxt = crc_upd ^ expected_crc_r;                // RL6

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         CMCRC_IDLE:   state_nxt = CMCRC_FRAME;
         CMCRC_FRAME:  if (word_in && word_cnt_r == LAST_WORD) state_nxt = CMCRC_FCRC;
         CMCRC_FCRC: begin
            if (frame_bad) begin
               state_nxt = CMCRC_ERR;                                            // RL2
            end else if (crc_in) begin
               state_nxt = (frame_cnt_r == LAST_FRM) ? CMCRC_EXP_LO : CMCRC_FRAME;
            end
         end
         CMCRC_EXP_LO: if (cfg_valid_i) state_nxt = CMCRC_EXP_HI;
         CMCRC_EXP_HI: if (cfg_valid_i) state_nxt = CMCRC_USER;
         CMCRC_USER:   state_nxt = CMCRC_USER;                                   // RL7
         CMCRC_ERR:    state_nxt = CMCRC_ERR;
      endcase
      if (restart) begin
         state_nxt = CMCRC_IDLE;                                                 // RL7
      end
   end

   always_ff @(posedge core_clk_i) begin
      state_r <= state_nxt;
   end

   // configuration load counters and per-frame crc
   always_ff @(posedge core_clk_i) begin
      if (restart || state_r == CMCRC_IDLE) begin
         word_cnt_r  <= '0;
         frame_cnt_r <= '0;
         wr_addr_r   <= '0;
         frame_crc_r <= `CMCRC_CRC16_INIT;
      end else if (word_in) begin
         word_cnt_r  <= (word_cnt_r == LAST_WORD) ? '0 : word_cnt_r + 1'b1;
         wr_addr_r   <= wr_addr_r + 1'b1;
         frame_crc_r <= frame_crc_upd;
      end else if (crc_in && !frame_bad) begin
         frame_cnt_r <= frame_cnt_r + 1'b1;
         frame_crc_r <= `CMCRC_CRC16_INIT;
      end
   end

   // status pin low while held in reconfiguration and after a bad frame
   always_ff @(posedge core_clk_i) begin
      if (restart) begin
         config_status_n_o <= 1'b0;
      end else if (frame_bad) begin
         config_status_n_o <= 1'b0;                                              // RL17
      end else if (state_r == CMCRC_IDLE) begin
         config_status_n_o <= 1'b1;
      end
   end

   // expected crc: from the stream at load end, or from the test port in user mode
   always_ff @(posedge core_clk_i) begin
      if (restart) begin
         exp_lo_r       <= '0;
         expected_crc_r <= '0;
         exp_tgl_r      <= 1'b0;
      end else begin
         if (cfg_valid_i && state_r == CMCRC_EXP_LO) begin
            exp_lo_r <= cfg_data_i;                                              // RL3
         end
         if (exp_done) begin
            expected_crc_r <= {cfg_data_i, exp_lo_r};                            // RL4
            exp_tgl_r      <= ~exp_tgl_r;
         end else if (ld_event && state_r == CMCRC_USER) begin
            expected_crc_r <= ld_word_r;                                         // RL12
            exp_tgl_r      <= ~exp_tgl_r;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      user_mode_o <= ~restart & (state_nxt == CMCRC_USER);
      cfg_state_o <= state_nxt;
   end

   cmcrc_cell_mem #(
      .WIDTH  (`CMCRC_WORD_W + 1),
      .DEPTH  (DEPTH),
      .ADDR_W (ADDR_W)
   ) u_cell_mem (
      .core_clk_i (core_clk_i),
      .wr_en_i    (word_in & ~restart),
      .wr_addr_i  (wr_addr_r),
      .wr_data_i  ({cfg_excl_i, cfg_data_i}),
      .rd_addr_i  (scan_addr_r),
      .rd_data_o  (rd_data)
   );

   // background scan; an error does not stop it, only reconfiguration, reset or a low crc_check_en_i does
   always_ff @(posedge core_clk_i) begin
      if (restart || !scan_on) begin
         scan_addr_r <= '0;
         rd_vld_r    <= 1'b0;
         rd_last_r   <= 1'b0;
      end else begin
         scan_addr_r <= (scan_addr_r == LAST_ADDR) ? '0 : scan_addr_r + 1'b1;   // RL18
         rd_vld_r    <= 1'b1;
         rd_last_r   <= (scan_addr_r == LAST_ADDR);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (restart || !scan_on || (rd_vld_r && rd_last_r)) begin
         crc_r <= `CMCRC_CRC32_INIT;                                             // RL6
      end else if (rd_vld_r) begin
         crc_r <= crc_upd;
      end
   end

   // the flag only moves at a pass boundary or on restart so a partial pass never reports
   always_ff @(posedge core_clk_i) begin
      if (restart) begin
         crc_signature_o <= '0;                                                  // RL19
         crc_error_o     <= 1'b0;
      end else if (scan_on && rd_vld_r && rd_last_r) begin
         crc_signature_o <= sig_nxt;
         crc_error_o     <= (sig_nxt != '0);                                     // RL10
      end
   end

   // ---------------- test access port logic on tck ----------------
   always_ff @(posedge tck_i) begin
      trst_s1_r <= reset_i;
      trst_s2_r <= trst_s1_r;
      um_s1_r   <= user_mode_o;
      um_s2_r   <= um_s1_r;
      ex_s1_r   <= exp_tgl_r;
      ex_s2_r   <= ex_s1_r;
      ex_s3_r   <= ex_s2_r;
   end

   wire ld_sel = (ir_r == `CMCRC_LOAD_EXP_OP) & um_s2_r;                        // RL12

   always_ff @(posedge tck_i) begin
      if (trst_s2_r) begin
         ir_sh_r <= `CMCRC_IR_RESET;
         ir_r    <= `CMCRC_IR_RESET;
      end else if (jtag_shift_ir_i) begin
         ir_sh_r <= {tdi_i, ir_sh_r[`CMCRC_IR_W-1:1]};
      end else if (jtag_update_ir_i) begin
         ir_r    <= ir_sh_r;
      end
   end

   // shadow copy follows the stored value; word is stable while its toggle crosses
   always_ff @(posedge tck_i) begin
      if (trst_s2_r) begin
         shadow_r <= '0;
      end else if (ex_s2_r ^ ex_s3_r) begin
         shadow_r <= expected_crc_r;
      end
   end

   always_ff @(posedge tck_i) begin
      if (trst_s2_r) begin
         dr_r      <= '0;
         ld_word_r <= '0;
         ld_tgl_r  <= 1'b0;
         tdo_o     <= 1'b0;
      end else begin
         if (jtag_capture_dr_i && ld_sel) begin
            dr_r <= shadow_r;                                                    // RL11
         end else if (jtag_shift_dr_i && ld_sel) begin
            dr_r  <= {tdi_i, dr_r[`CMCRC_CRC32_W-1:1]};                          // RL11
            tdo_o <= dr_r[0];
         end else if (jtag_shift_ir_i) begin
            tdo_o <= ir_sh_r[0];
         end
         if (jtag_update_dr_i && ld_sel) begin
            ld_word_r <= dr_r;
            ld_tgl_r  <= ~ld_tgl_r;
         end
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   sequence s_pass_end;
      scan_on && rd_vld_r && rd_last_r && !restart;
   endsequence

   sequence s_flag_follows;
      crc_error_o == (crc_signature_o != '0);
   endsequence

   a_frame_bad_status: assert property (frame_bad && rcfg_s2_r |=> !config_status_n_o [*2]) // RL17
      else $error("frame crc mismatch did not pull status low");

   a_error_holds_load: assert property (state_r == CMCRC_ERR && !restart |=> state_r == CMCRC_ERR) // RL2
      else $error("loading resumed after a bad frame");

   a_expected_kept: assert property (exp_done && !restart
                                    |=> expected_crc_r == {$past(cfg_data_i), $past(exp_lo_r)} && user_mode_o) // RL4
      else $error("expected crc not stored at load end");

   a_scan_disabled: assert property (!scan_on |=> !rd_vld_r) // RL5
      else $error("scan ran while disabled");

   a_flag_at_pass: assert property (s_pass_end |=> s_flag_follows) // RL10
      else $error("error flag disagrees with signature");

   a_flag_stable: assert property (!(scan_on && rd_vld_r && rd_last_r) && !restart |=> $stable(crc_error_o)) // RL19
      else $error("error flag moved outside a pass end");

   a_reconfig_clears: assert property (!rcfg_s2_r |=> state_r == CMCRC_IDLE && !crc_error_o) // RL7
      else $error("reconfiguration did not clear the checker");

   a_scan_on_error: assert property (scan_on && crc_error_o && !restart ##1 (scan_on && !restart) |=> rd_vld_r) // RL18
      else $error("scan stopped after an error");

   a_excluded_skip: assert property (rd_vld_r && !rd_last_r && rd_excl && scan_on && !restart |=> $stable(crc_r)) // RL8
      else $error("excluded word changed the crc");

   a_load_user_only: assert property (@(posedge tck_i) disable iff (trst_s2_r)
                                      jtag_update_dr_i && !ld_sel |=> $stable(ld_tgl_r)) // RL12
      else $error("storage load taken outside user mode");

endmodule

`default_nettype wire

/* sim/cmcrc_tap_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cmcrc_cfg.svh"

module cmcrc_tap_host (
   input  wire logic tdo_i,
   output logic      tck_o,
   output logic      tdi_o,
   output logic      shift_ir_o,
   output logic      update_ir_o,
   output logic      capture_dr_o,
   output logic      shift_dr_o,
   output logic      update_dr_o
);
   initial begin
      tck_o = 1'b0;
      tdi_o = 1'b1;
      shift_ir_o = 1'b0;
      update_ir_o = 1'b0;
      capture_dr_o = 1'b0;
      shift_dr_o = 1'b0;
      update_dr_o = 1'b0;
   end

   // tck stands low between frames; everything changes just after its falling edge
   task automatic tick();
      #62.5 tck_o = 1'b1;
      #62.5 tck_o = 1'b0;
   endtask

   task automatic idle(input int n);
      repeat (n) tick();
   endtask

   // the caller issues this in user mode and also after a bad frame, outside user mode
   task automatic load_word(input logic [31:0] val, output logic [31:0] old);
      logic [`CMCRC_IR_W-1:0] op;
      op = `CMCRC_LOAD_EXP_OP;
      shift_ir_o = 1'b1;
      for (int i = 0; i < `CMCRC_IR_W; i++) begin
         tdi_o = op[i];
         tick();
      end
      shift_ir_o = 1'b0;
      update_ir_o = 1'b1;
      tick();
      update_ir_o = 1'b0;
      capture_dr_o = 1'b1;
      tick();
      capture_dr_o = 1'b0;
      shift_dr_o = 1'b1;
      for (int i = 0; i < 32; i++) begin
         tdi_o = val[i];
         tick();
         old[i] = tdo_i;
      end
      shift_dr_o = 1'b0;
      update_dr_o = 1'b1;
      tick();
      update_dr_o = 1'b0;
      // released line: show the inverse so a stale level is never mistaken for data
      tdi_o = ~tdi_o;
   endtask
endmodule

`default_nettype wire

/* sim/cmcrc_checker_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cmcrc_cfg.svh"

module cmcrc_checker_test;
   import cmcrc_pkg::*;
   localparam int FW    = 8;
   localparam int NF    = 4;
   localparam int PASS  = FW * NF + 1;
   localparam int LIMIT = 20000;

   logic         core_clk = 1'b0;
   logic         reset = 1'b1;
   logic         rcfg_n = 1'b1;
   logic         cfg_valid = 1'b0;
   logic [15:0]  cfg_data = 16'h0000;
   logic         cfg_excl = 1'b0;
   logic         chk_en = 1'b0;
   logic         tck, tdi, sh_ir, up_ir, cap_dr, sh_dr, up_dr, tdo;
   logic         status_n, user_mode, crc_err;
   logic [31:0]  sig, exp_ok, bad_exp, old;
   cmcrc_state_t st;
   int           fails = 0;
   int           tests_run = 0;
   int           cycles = 0;

   always #5 core_clk = ~core_clk;

   cmcrc_checker #(.FRAME_WORDS(FW), .NUM_FRAMES(NF)) i_cmcrc_checker (
      .core_clk_i(core_clk), .reset_i(reset), .reconfig_request_n_i(rcfg_n),
      .cfg_valid_i(cfg_valid), .cfg_data_i(cfg_data), .cfg_excl_i(cfg_excl),
      .crc_check_en_i(chk_en), .tck_i(tck), .tdi_i(tdi), .jtag_shift_ir_i(sh_ir),
      .jtag_update_ir_i(up_ir), .jtag_capture_dr_i(cap_dr), .jtag_shift_dr_i(sh_dr),
      .jtag_update_dr_i(up_dr), .tdo_o(tdo), .config_status_n_o(status_n),
      .user_mode_o(user_mode), .crc_error_o(crc_err), .crc_signature_o(sig), .cfg_state_o(st));

   cmcrc_tap_host i_cmcrc_tap_host (
      .tdo_i(tdo), .tck_o(tck), .tdi_o(tdi), .shift_ir_o(sh_ir), .update_ir_o(up_ir),
      .capture_dr_o(cap_dr), .shift_dr_o(sh_dr), .update_dr_o(up_dr));

   function automatic logic [15:0] wd(input int i);
      return 16'hA5C3 ^ (16'h1357 * i[15:0]);
   endfunction

   function automatic logic [15:0] c16(input logic [15:0] c, input logic [15:0] d);
      for (int b = 15; b >= 0; b--) c = {c[14:0], 1'b0} ^ ({16{c[15] ^ d[b]}} & `CMCRC_CRC16_POLY);
      return c;
   endfunction

   function automatic logic [31:0] c32(input logic [31:0] c, input logic [15:0] d);
      for (int b = 15; b >= 0; b--) c = {c[30:0], 1'b0} ^ ({32{c[31] ^ d[b]}} & `CMCRC_CRC32_POLY);
      return c;
   endfunction

   task automatic close_out();
      if (fails == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic put(input logic [15:0] d, input logic x);
      @(negedge core_clk);
      cfg_valid = 1'b1;
      cfg_data = d;
      cfg_excl = x;
   endtask

   // every fifth word from index 3 stands for memory-block or i/o content
   task automatic send_cfg(input int bad, input logic [31:0] exp);
      logic [15:0] c;
      for (int f = 0; f < NF; f++) begin
         c = `CMCRC_CRC16_INIT;
         for (int w = 0; w < FW; w++) begin
            put(wd(f * FW + w), (f * FW + w) % 5 == 3);
            c = c16(c, wd(f * FW + w));
         end
         put(c ^ {15'h0000, f == bad}, 1'b0);
      end
      put(exp[15:0], 1'b0);
      put(exp[31:16], 1'b0);
      @(negedge core_clk);
      cfg_valid = 1'b0;
   endtask

   task automatic wait_frame();
      for (int k = 0; k < 20 && st !== CMCRC_FRAME; k++) @(negedge core_clk);
      chk_bit(st === CMCRC_FRAME, 1'b1);
      chk_bit(status_n, 1'b1);
   endtask

   // pin held well past its two-flop synchroniser
   task automatic reconfig();
      @(negedge core_clk);
      rcfg_n = 1'b0;
      repeat (6) @(negedge core_clk);
      chk_bit(user_mode, 1'b0);
      chk_bit(crc_err, 1'b0);
      rcfg_n = 1'b1;
      wait_frame();
   endtask

   task automatic t_reset();
      fork
         repeat (16) @(negedge core_clk);
         i_cmcrc_tap_host.idle(3);
      join
      chk_bit(status_n, 1'b0);
      chk_bit(user_mode, 1'b0);
      chk_bit(crc_err, 1'b0);
      chk_word(sig, 32'h00000000);
      @(negedge core_clk);
      reset = 1'b0;
      // the tck side only leaves reset while tck runs, so clock it out before the first load
      i_cmcrc_tap_host.idle(3);
      wait_frame();
   endtask

   task automatic t_bad_frame();
      send_cfg(1, exp_ok);
      chk_bit(status_n, 1'b0);
      chk_bit(user_mode, 1'b0);
      i_cmcrc_tap_host.load_word(bad_exp, old);
      chk_bit(user_mode, 1'b0);
      reconfig();
   endtask

   task automatic t_wrong_exp();
      send_cfg(-1, bad_exp);
      chk_bit(status_n, 1'b1);
      chk_bit(user_mode, 1'b1);
      repeat (3 * PASS) @(negedge core_clk);
      chk_bit(crc_err, 1'b0);
      chk_word(sig, 32'h00000000);
      chk_en = 1'b1;
      repeat (PASS + 3) @(negedge core_clk);
      chk_bit(crc_err, 1'b1);
      chk_word(sig, exp_ok ^ bad_exp);
      repeat (PASS) @(negedge core_clk);
      chk_bit(crc_err, 1'b1);
   endtask

   task automatic t_inject();
      i_cmcrc_tap_host.load_word(exp_ok, old);
      chk_word(old, bad_exp);
      repeat (PASS + 4) @(negedge core_clk);
      chk_bit(crc_err, 1'b0);
      chk_word(sig, 32'h00000000);
      i_cmcrc_tap_host.load_word(exp_ok ^ 32'h80000001, old);
      chk_word(old, exp_ok);
      repeat (PASS + 4) @(negedge core_clk);
      chk_bit(crc_err, 1'b1);
      chk_word(sig, 32'h80000001);
      reconfig();
   endtask

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fails++;
         close_out();
      end
   end

   initial begin
      exp_ok = `CMCRC_CRC32_INIT;
      for (int i = 0; i < FW * NF; i++) if (i % 5 != 3) exp_ok = c32(exp_ok, wd(i));
      bad_exp = exp_ok ^ 32'h00000100;
      t_reset();
      t_bad_frame();
      t_wrong_exp();
      t_inject();
      close_out();
   end
endmodule

`default_nettype wire
